/* rtl/fct_pkg.sv */
// package: constants and types for the feedback conversion table
package fct_pkg;
  localparam int WORD_W = 24;
  localparam int FRAC_W = 5;
  localparam int INT_W = 19;
  localparam int SMP_W = 16;
  localparam int SMP_LO = 8;
  localparam int BIAS_FRAC_W = 8;
  localparam int ACC_W = INT_W + BIAS_FRAC_W;
  localparam int FMT_LO = 20;
  localparam int FMT_W = 4;
  localparam int SUM_BIT = 16;
  localparam int UNSIGNED_BIT = 19;
  localparam int ADDR_W = 16;
  localparam int ENC_IDX_LO = 2;
  localparam int ENC_IDX_W = 4;
  localparam logic [15:0] ENC_COUNT_OFS = 16'h0002;
  localparam logic [3:0] FMT_ONE_T = 4'h0;
  localparam logic [3:0] FMT_ANALOG = 4'h1;
  localparam logic [3:0] FMT_INTEG = 4'h5;
  localparam logic [3:0] FMT_PARALLEL = 4'h8;
  localparam logic [3:0] FMT_NO_INTERP = 4'hC;
  // bus map, byte offsets within the slave
  localparam int OFF_W = 12;
  localparam logic [11:0] OFF_Y = 12'h000;
  localparam logic [11:0] OFF_X = 12'h100;
  localparam logic [11:0] OFF_CTRL = 12'h200;
  localparam logic [11:0] OFF_STAT = 12'h204;
  localparam int CTRL_EN_BIT = 0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_OVR_BIT = 1;
  localparam int STAT_CNT_LO = 16;
  localparam int CNT_W = 16;
  typedef enum logic [2:0] {
    FCT_IDLE, FCT_FETCH, FCT_ISSUED, FCT_DATA, FCT_CALC
  } fct_phase_type;
endpackage : fct_pkg

/* rtl/fct_convert.sv */
// combinational conversion of one source word to a position word
`timescale 1ns/1ps
`default_nettype none
module fct_convert
  import fct_pkg::*;
(
  input wire logic [FMT_W-1:0] fmt,
  input wire logic unsignedSel,
  input wire logic [WORD_W-1:0] srcWord,
  input wire logic [FRAC_W-1:0] tFrac,
  input wire logic [FRAC_W-1:0] parFlags,
  input wire logic [WORD_W-1:0] bias,
  input wire logic [ACC_W-1:0] accIn,
  output logic [WORD_W-1:0] result,
  output logic [ACC_W-1:0] accOut
);
  logic [SMP_W-1:0] sample;
  logic [INT_W-1:0] sampleExt;
  logic [INT_W-1:0] count;

  // sample extension, integral step and format select
  always_comb begin
    sample = srcWord[SMP_LO +: SMP_W];
    if (unsignedSel) begin
      sampleExt = {{(INT_W-SMP_W){1'b0}}, sample};
    end else begin
      sampleExt = {{(INT_W-SMP_W){sample[SMP_W-1]}}, sample};
    end
    count = srcWord[INT_W-1:0];
    // bias is added in 1/256 LSB units below the sample
    accOut = accIn + {sampleExt, {BIAS_FRAC_W{1'b0}}}
      + {{(ACC_W-WORD_W){bias[WORD_W-1]}}, bias};
    case (fmt)
      FMT_ONE_T: result = {count, tFrac};
      FMT_PARALLEL: result = {count, parFlags};
      FMT_NO_INTERP: result = {count, {FRAC_W{1'b0}}};
      // no extension: a rolling input simply wraps
      FMT_ANALOG: result = {sampleExt, {FRAC_W{1'b0}}};
      FMT_INTEG: result = {accOut[ACC_W-1 -: INT_W], {FRAC_W{1'b0}}};
      default: result = '0;
    endcase
  end
endmodule : fct_convert
`default_nettype wire

/* rtl/fct_table.sv */
// feedback conversion table engine with AHB-Lite register access
`timescale 1ns/1ps
`default_nettype none
module fct_table
  import fct_pkg::*;
#(
  parameter int LINES = 32
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic servoTick,
  input wire logic [WORD_W-1:0] srcRdData,
  input wire logic [FRAC_W-1:0] tFrac,
  input wire logic [FRAC_W-1:0] parFlags,
  output logic [ADDR_W-1:0] srcAddr,
  output logic srcRd,
  output logic srcYSpace,
  output logic [ENC_IDX_W-1:0] encSel,
  output logic cycleDone
);
  localparam int LW = $clog2(LINES);
  localparam int IW = LW + 1;

  typedef struct packed {
    logic [LINES-1:0][WORD_W-1:0] ySetup;
    logic [LINES-1:0][WORD_W-1:0] xRes;
    logic enable;
    logic overrun;
    fct_phase_type phase;
    logic [IW-1:0] line;
    logic [WORD_W-1:0] prevResult;
    logic prevSummed;
    logic [WORD_W-1:0] srcWord;
    logic [FRAC_W-1:0] tFrac;
    logic [FRAC_W-1:0] parFlags;
    logic [ADDR_W-1:0] srcAddr;
    logic srcRd;
    logic srcYSpace;
    logic [ENC_IDX_W-1:0] encSel;
    logic cycleDone;
    logic [CNT_W-1:0] cycleCount;
    logic wrPend;
    logic [OFF_W-1:0] wrAddr;
    logic [31:0] hrdata;
    logic hreadyout;
  } fct_state_type;

  fct_state_type s_r;
  fct_state_type s_nxt;
  logic [WORD_W-1:0] cur;
  logic [FMT_W-1:0] fmt;
  logic [LW-1:0] li;
  logic [LW-1:0] li1;
  logic [WORD_W-1:0] convRes;
  logic [ACC_W-1:0] accOut;
  logic [1:0] adv;
  logic [IW-1:0] nl;
  logic sumNow;
  logic resWr;
  logic [LW-1:0] resIdx;
  logic [WORD_W-1:0] resVal;
  logic busAcc;

  function automatic logic inTable(logic [OFF_W-1:0] a,
                                   logic [OFF_W-1:0] base);
    return (a >= base) && (a < base + OFF_W'(LINES * 4))
      && (a[1:0] == 2'h0);
  endfunction : inTable

  function automatic logic [LW-1:0] lineOf(logic [OFF_W-1:0] a);
    return a[2 +: LW];
  endfunction : lineOf

  function automatic logic isAnalog(logic [FMT_W-1:0] f);
    return (f == FMT_ANALOG) || (f == FMT_INTEG);
  endfunction : isAnalog

  function automatic logic [31:0] readReg(logic [OFF_W-1:0] a);
    logic [31:0] d;
    d = 32'h0000_0000;
    if (inTable(a, OFF_Y)) begin
      d = {8'h00, s_r.ySetup[lineOf(a)]};
    end else if (inTable(a, OFF_X)) begin
      d = {8'h00, s_r.xRes[lineOf(a)]};
    end else if (a == OFF_CTRL) begin
      d[CTRL_EN_BIT] = s_r.enable;
    end else if (a == OFF_STAT) begin
      d[STAT_BUSY_BIT] = (s_r.phase != FCT_IDLE);
      d[STAT_OVR_BIT] = s_r.overrun;
      d[STAT_CNT_LO +: CNT_W] = s_r.cycleCount;
    end
    return d;
  endfunction : readReg

  assign cur = s_r.ySetup[li];
  assign fmt = cur[FMT_LO +: FMT_W];
  assign li = s_r.line[LW-1:0];
  assign li1 = LW'(s_r.line + 1'b1);
  assign busAcc = hsel && htrans[1] && hready;

  fct_convert u_conv (
    .fmt(fmt),
    .unsignedSel(cur[UNSIGNED_BIT]),
    .srcWord(s_r.srcWord),
    .tFrac(s_r.tFrac),
    .parFlags(s_r.parFlags),
    .bias(s_r.ySetup[li1]),
    .accIn({s_r.xRes[li1][WORD_W-1:FRAC_W],
            s_r.xRes[li][BIAS_FRAC_W-1:0]}),
    .result(convRes),
    .accOut(accOut)
  );

  // engine walk, then bus writes, which win over the engine
  always_comb begin
    s_nxt = s_r;
    s_nxt.srcRd = 1'b0;
    s_nxt.cycleDone = 1'b0;
    adv = 2'h0;
    nl = '0;
    sumNow = 1'b0;
    resWr = 1'b0;
    resIdx = li;
    resVal = '0;
    case (s_r.phase)
      FCT_IDLE: begin
        if (servoTick && s_r.enable) begin
          s_nxt.phase = FCT_FETCH;
          s_nxt.line = '0;
          s_nxt.prevSummed = 1'b0;
          s_nxt.prevResult = '0;
        end
      end
      FCT_FETCH: begin
        // unsupported formats, or an integral with no bias line, skip
        if ((fmt == FMT_ONE_T || fmt == FMT_PARALLEL
             || fmt == FMT_NO_INTERP || fmt == FMT_ANALOG
             || fmt == FMT_INTEG) && !(fmt == FMT_INTEG
             && li == LW'(LINES - 1))) begin
          s_nxt.srcRd = 1'b1;
          s_nxt.srcYSpace = isAnalog(fmt);
          if (isAnalog(fmt)) begin
            s_nxt.srcAddr = cur[ADDR_W-1:0];
          end else begin
            s_nxt.srcAddr = cur[ADDR_W-1:0] + ENC_COUNT_OFS;
          end
          // parallel flags come from the next encoder, base index plus one
          s_nxt.encSel = cur[ENC_IDX_LO +: ENC_IDX_W]
            + ENC_IDX_W'(fmt == FMT_PARALLEL);
          s_nxt.phase = FCT_ISSUED;
        end else begin
          s_nxt.prevSummed = 1'b0;
          adv = 2'h1;
        end
      end
      FCT_ISSUED: s_nxt.phase = FCT_DATA;
      FCT_DATA: begin
        s_nxt.srcWord = srcRdData;
        s_nxt.tFrac = tFrac;
        s_nxt.parFlags = parFlags;
        s_nxt.phase = FCT_CALC;
      end
      FCT_CALC: begin
        // an integral never sums: it would feed back into itself
        sumNow = cur[SUM_BIT] && !s_r.prevSummed
          && fmt != FMT_INTEG;
        resVal = sumNow ? convRes + s_r.prevResult : convRes;
        resWr = 1'b1;
        if (fmt == FMT_INTEG) begin
          s_nxt.xRes[li][BIAS_FRAC_W-1:0] = accOut[BIAS_FRAC_W-1:0];
          resIdx = li1;
          adv = 2'h2;
        end else begin
          adv = 2'h1;
        end
        s_nxt.xRes[resIdx] = resVal;
        s_nxt.prevResult = resVal;
        s_nxt.prevSummed = sumNow;
      end
      default: s_nxt.phase = FCT_IDLE;
    endcase
    // step to the next entry or finish the walk
    if (adv != 2'h0) begin
      nl = s_r.line + IW'(adv);
      if (nl >= IW'(LINES)) begin
        s_nxt.phase = FCT_IDLE;
        s_nxt.cycleDone = 1'b1;
        s_nxt.cycleCount = s_r.cycleCount + 1'b1;
      end else begin
        s_nxt.line = nl;
        s_nxt.phase = FCT_FETCH;
      end
    end
    // data phase of a write: table, control, overrun clear
    if (s_r.wrPend) begin
      if (inTable(s_r.wrAddr, OFF_Y)) begin
        s_nxt.ySetup[lineOf(s_r.wrAddr)] = hwdata[WORD_W-1:0];
      end
      if (inTable(s_r.wrAddr, OFF_X)) begin
        s_nxt.xRes[lineOf(s_r.wrAddr)] = hwdata[WORD_W-1:0];
      end
      if (s_r.wrAddr == OFF_CTRL) begin
        s_nxt.enable = hwdata[CTRL_EN_BIT];
      end
      if (s_r.wrAddr == OFF_STAT && hwdata[STAT_OVR_BIT]) begin
        s_nxt.overrun = 1'b0;
      end
    end
    // a tick during a walk is dropped; set beats clear
    if (servoTick && s_r.phase != FCT_IDLE) begin
      s_nxt.overrun = 1'b1;
    end
    // address phase: zero wait states, read data registered now
    s_nxt.wrPend = busAcc && hwrite;
    s_nxt.wrAddr = haddr[OFF_W-1:0];
    if (busAcc && !hwrite) begin
      s_nxt.hrdata = readReg(haddr[OFF_W-1:0]);
    end
  end

  // single state register; reset also clears every integral
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s_r <= '0;
      s_r.hreadyout <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign hreadyout = s_r.hreadyout;
  assign hresp = 1'b0;
  assign hrdata = s_r.hrdata;
  assign srcAddr = s_r.srcAddr;
  assign srcRd = s_r.srcRd;
  assign srcYSpace = s_r.srcYSpace;
  assign encSel = s_r.encSel;
  assign cycleDone = s_r.cycleDone;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  chk_read_pulse: assert property (
      srcRd |=> !srcRd && s_r.phase == FCT_DATA)
    else $error("source read not a single pulse");
  chk_enc_base_ofs: assert property (srcRd && !srcYSpace
      |-> srcAddr == $past(cur[ADDR_W-1:0]) + ENC_COUNT_OFS)
    else $error("encoder counter address not base plus two");
  chk_par_next_enc: assert property (s_r.phase == FCT_FETCH
      && fmt == FMT_PARALLEL |=> encSel
      == $past(cur[ENC_IDX_LO +: ENC_IDX_W]) + 4'h1)
    else $error("parallel flags not from next encoder");
  chk_no_interp_frac: assert property (resWr && fmt == FMT_NO_INTERP
      && !sumNow |-> resVal[FRAC_W-1:0] == 5'h00)
    else $error("non-interpolated fraction not zero");
  chk_onet_frac: assert property (resWr && fmt == FMT_ONE_T
      && !sumNow |-> resVal[FRAC_W-1:0] == s_r.tFrac)
    else $error("timer fraction not applied");
  chk_analog_scale: assert property (resWr && fmt == FMT_ANALOG
      && !sumNow && !cur[UNSIGNED_BIT] |-> $signed(resVal)
      == $signed(s_r.srcWord[SMP_LO +: SMP_W]) * 32)
    else $error("signed analog scaling wrong");
  chk_unsigned_top: assert property (resWr && fmt == FMT_ANALOG
      && !sumNow && cur[UNSIGNED_BIT] |-> resVal[WORD_W-1 -: 3] == 3'h0)
    else $error("unsigned analog sign-extended");
  // a bus write in the same cycle may overwrite the integral
  chk_integ_line: assert property (resWr && fmt == FMT_INTEG
      |=> s_r.xRes[$past(li1)] == $past(resVal) || $past(s_r.wrPend))
    else $error("integral not in second line");
  // the entry after a summing one writes its own result unsummed
  chk_sum_once: assert property (resWr && s_r.prevSummed
      |-> resVal == convRes)
    else $error("consecutive summing entries both summed");
  chk_bus_wr_x: assert property (s_r.wrPend
      && inTable(s_r.wrAddr, OFF_X) |=> s_r.xRes[$past(lineOf(s_r.wrAddr))]
      == $past(hwdata[WORD_W-1:0]))
    else $error("result word write lost");
  chk_walk_end: assert property (cycleDone
      |-> s_r.phase == FCT_IDLE && $past(s_r.phase) != FCT_IDLE)
    else $error("walk end without a walk");

  cov_integ_entry: cover property (resWr && fmt == FMT_INTEG);
  cov_summed_entry: cover property (resWr && sumNow);
  cov_full_walk: cover property (cycleDone);
endmodule : fct_table
`default_nettype wire

/* tb/fct_source_model.sv */
// behavioural encoder counters and converter registers on the source link
`timescale 1ns/1ps
`default_nettype none
module fct_source_model
  import fct_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srcRd,
  input wire logic [ADDR_W-1:0] srcAddr,
  input wire logic srcYSpace,
  input wire logic [ENC_IDX_W-1:0] encSel,
  output logic [WORD_W-1:0] srcRdData,
  output logic [FRAC_W-1:0] tFrac,
  output logic [FRAC_W-1:0] parFlags
);
  logic [WORD_W-1:0] mem [128];
  logic [FRAC_W-1:0] timerFrac [16];
  logic [FRAC_W-1:0] subFlags [16];
  // x counters sit two above their base, y holds converter words
  initial begin
    foreach (mem[i]) mem[i] = 24'h000000;
    foreach (timerFrac[i]) timerFrac[i] = 5'h00;
    foreach (subFlags[i]) subFlags[i] = 5'h00;
    mem[7'h0E] = 24'h000123;
    mem[7'h0A] = 24'h000010;
    mem[7'h12] = 24'h000007;
    mem[7'h46] = 24'h8000FF;
    mem[7'h47] = 24'hFFFF12;
    mem[7'h4F] = 24'h000300;
    timerFrac[2] = 5'h0A;
    subFlags[5] = 5'h11;
    srcRdData = 24'h000000;
    tFrac = 5'h00;
    parFlags = 5'h00;
  end
  // answer the cycle after the strobe, then scramble so stale data shows
  always @(posedge ref_clk) begin
    if (srcRd) begin
      srcRdData <= mem[{srcYSpace, srcAddr[5:0]}];
      tFrac <= timerFrac[encSel];
      parFlags <= subFlags[encSel];
    end else begin
      srcRdData <= ~srcRdData;
      tFrac <= ~tFrac;
      parFlags <= ~parFlags;
    end
  end
endmodule : fct_source_model
`default_nettype wire

/* tb/fct_table_tb.sv */
// self-checking bench: table setup over the bus, walks, result reads
`timescale 1ns/1ps
`default_nettype none
module fct_table_tb;
  import fct_pkg::*;
  localparam int NLINES = 16;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b1;
  logic [31:0] haddr = 32'h00000000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h00000000;
  logic servoTick = 1'b0;
  logic hreadyout, hresp, srcRd, srcYSpace, cycleDone;
  logic [31:0] hrdata;
  logic [WORD_W-1:0] srcRdData;
  logic [FRAC_W-1:0] tFrac, parFlags;
  logic [ADDR_W-1:0] srcAddr;
  logic [ENC_IDX_W-1:0] encSel;
  int n_fail = 0;
  int checks_done = 0;
  // line 9 has an unsupported format and must be skipped
  logic [23:0] ySet [10] = '{24'hC0C00C, 24'h00C008, 24'h80C010, 24'h10C006,
    24'h18C007, 24'h11C006, 24'h11C007, 24'h50C00F, 24'h000500, 24'h20C000};

  always #2.5 ref_clk = ~ref_clk;

  fct_table #(.LINES(NLINES)) u_dut (.ref_clk(ref_clk), .rstn(rstn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .servoTick(servoTick), .srcRdData(srcRdData), .tFrac(tFrac),
    .parFlags(parFlags), .srcAddr(srcAddr), .srcRd(srcRd),
    .srcYSpace(srcYSpace), .encSel(encSel), .cycleDone(cycleDone));

  fct_source_model u_src (.ref_clk(ref_clk), .srcRd(srcRd),
    .srcAddr(srcAddr), .srcYSpace(srcYSpace), .encSel(encSel),
    .srcRdData(srcRdData), .tFrac(tFrac), .parFlags(parFlags));

  task automatic report_and_stop;
    if (n_fail == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop

  // one single transfer; entered just after a rising edge
  task automatic bus_xfer(input logic wr, input logic [31:0] a,
                          input logic [31:0] d, output logic [31:0] q);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    q = hrdata;
  endtask : bus_xfer

  task automatic bus_write(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus_xfer(1'b1, a, d, q);
  endtask : bus_write

  task automatic check_read(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus_xfer(1'b0, a, 32'h00000000, q);
    checks_done++;
    if (q !== exp || hresp !== 1'b0) begin
      n_fail++;
      $display("ERROR %0t read %h got %h want %h", $time, a, q, exp);
    end
  endtask : check_read

  // tick, optionally a second tick while busy, then bounded wait for done
  task automatic walk(input logic twice);
    int n;
    servoTick <= 1'b1;
    @(posedge ref_clk);
    servoTick <= 1'b0;
    if (twice) begin
      repeat (2) @(posedge ref_clk);
      servoTick <= 1'b1;
      @(posedge ref_clk);
      servoTick <= 1'b0;
    end
    n = 0;
    while (cycleDone !== 1'b1 && n < 400) begin
      @(posedge ref_clk);
      n++;
    end
    checks_done++;
    if (n >= 400) begin
      n_fail++;
      $display("ERROR %0t walk never finished", $time);
    end
  endtask : walk

  // main sequence
  initial begin
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    check_read(32'h00000120, 32'h00000000);
    check_read(32'h00000300, 32'h00000000);
    for (int i = 0; i < 10; i++) begin
      bus_write(32'(4 * i), {8'h00, ySet[i]});
    end
    bus_write(32'h00000200, 32'h00000001);
    walk(1'b0);
    check_read(32'h00000100, {8'h00, 19'h00123, 5'h00});
    check_read(32'h00000104, {8'h00, 19'h00010, 5'h0A});
    check_read(32'h00000108, {8'h00, 19'h00007, 5'h11});
    check_read(32'h0000010C, {8'h00, 19'h78000, 5'h00});
    check_read(32'h00000110, {8'h00, 19'h0FFFF, 5'h00});
    check_read(32'h00000114, {8'h00, 19'h07FFF, 5'h00});
    // signed -1 sample, second summing entry does not sum
    check_read(32'h00000118, {8'h00, 19'h7FFFF, 5'h00});
    check_read(32'h00000124, 32'h00000000);
    check_read(32'h00000120, {8'h00, 19'h00008, 5'h00});
    walk(1'b1);
    check_read(32'h00000120, {8'h00, 19'h00010, 5'h00});
    check_read(32'h00000204, 32'h00020002);
    bus_write(32'h00000204, 32'h00000002);
    check_read(32'h00000204, 32'h00020000);
    bus_write(32'h00000120, 32'h00001000);
    walk(1'b0);
    check_read(32'h00000120, {8'h00, 19'h00088, 5'h00});
    report_and_stop;
  end

  // a hang counts as a failure
  initial begin
    repeat (5000) @(posedge ref_clk);
    n_fail++;
    $display("ERROR %0t watchdog expired", $time);
    report_and_stop;
  end
endmodule : fct_table_tb
`default_nettype wire
